// ===== logic/sbl_pkg.sv
// Purpose: shared constants and types of the secure boot loader
// Assumes: 20 MHz reference clock, 32-bit classic Wishbone slave
// Notes: security bit positions, crc constants and register offsets
`default_nettype none
package sbl_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BOOT_DLY_US = 15; // least wait after reset
  localparam int unsigned BOOT_DLY_CYC = (BOOT_DLY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned DLY_W = 9;
  // ****************************************
  // image checksum
  // ****************************************
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_BYPASS = 32'h0D15AB1E;
  // ****************************************
  // security word layout
  // ****************************************
  localparam int unsigned SEC_NOJTAG = 0;
  localparam int unsigned SEC_NOLINK = 1;
  localparam int unsigned SEC_OTPBOOT = 5;
  localparam int unsigned SEC_REDUND = 7;
  localparam int unsigned SEC_LOCK0 = 8;
  localparam int unsigned SEC_MLOCK = 12;
  localparam int unsigned SEC_NOJOTP = 13;
  localparam logic [31:0] SEC_GP_MASK = 32'h003F8000; // bits 21..15
  localparam int unsigned SEC_UID_LO = 22;
  localparam logic [31:0] SEC_RESET = 32'hFFFFFFFF; // locked until loaded
  // ****************************************
  // otp and ram geometry
  // ****************************************
  localparam int unsigned OTP_SECTORS = 4;
  localparam int unsigned OTP_ROWS = 512;
  localparam int unsigned OTP_AW = 11;
  localparam int unsigned RAM_AW = 16;
  localparam logic [15:0] BOOT_ENTRY = 16'h0000;
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [7:0] ADR_SEC = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_PADDR = 8'h08;
  localparam logic [7:0] ADR_PDATA = 8'h0C;
  localparam logic [7:0] ADR_PCTRL = 8'h10;
  localparam int unsigned CTRL_ROW = 0;
  localparam int unsigned CTRL_SEC = 1;
  localparam int unsigned STAT_REJ = 4;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    S_RST, S_SECRD, S_SECCAP, S_FL, S_ORD, S_OCAP, S_OBYTE, S_RUN, S_FAIL
  } sbl_state_e;
  typedef enum logic [1:0] {PH_CNT, PH_PRG, PH_CRC} sbl_phase_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sbl_wb_s;
  typedef struct packed {
    logic we;
    logic [RAM_AW-1:0] adr;
    logic [31:0] dat;
  } sbl_ram_s;
  typedef struct packed {
    logic row;
    logic sec;
    logic [15:0] adr;
    logic [31:0] dat;
  } sbl_pgm_s;
  typedef struct packed {
    sbl_state_e st;
    sbl_phase_e ph;
    logic [DLY_W-1:0] dly;
    logic [31:0] sec;
    logic src_otp;
    logic ck1, ck2, ck3, dt1, dt2;
    logic [2:0] bitc;
    logic [7:0] shf;
    logic [31:0] wrd;
    logic [31:0] otpw;
    logic [1:0] bsel;
    logic [1:0] bidx;
    logic [31:0] cnt;
    logic [RAM_AW-1:0] raddr;
    logic [31:0] crc;
    logic [OTP_AW-1:0] otp_a;
    logic fl_cs_n;
    sbl_ram_s ram;
    logic start, fail, done, rej;
    logic ack;
    logic [31:0] rdat;
    logic [15:0] paddr;
    logic [31:0] pdata;
    sbl_pgm_s pgm;
  } sbl_state_s;
endpackage
`default_nettype wire

// ===== logic/sbl_top.sv
// Purpose: boot source pick, image load with crc check, security gating
// Assumes: otp read data valid one cycle after its read enable
// Notes: flash clock is sampled, never used as a clock
// Operation
// - pull-downs on gpio while reset held
// - wait 15 us after release, then boot
// - security bit 5 picks otp, else flash
// - image is count, program words, checksum
// - bypass value skips the checksum check
// - count and checksum are little endian
// - load from ram zero, start there
// - crc covers count and program only
// - reflected crc32, all-ones start, inverted
// - bit 0 blocks jtag tile access
// - bit 1 blocks other tile access
// - bit 7 enables otp redundant rows
// - bits 8 to 11 lock otp sectors
// - bit 12 rejects all otp programming
// - bit 13 blocks jtag otp access
// - bits 21..15 software general field
// - bits 31..22 extend jtag usercode
// - security word loaded from otp first
// - otp boot copies otp data to ram
// - otp is four sectors of 512 rows
// - otp programming through three ports
`timescale 1ns/100ps
`default_nettype none
module sbl_top #(
  parameter int unsigned DLY_CYC = sbl_pkg::BOOT_DLY_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register bus
  input wire sbl_pkg::sbl_wb_s WB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // pads
  output logic GPIO_PD_EN,
  // boot flash
  output logic FL_CS_N,
  input wire logic FL_SCK,
  input wire logic FL_MISO,
  // otp read side
  output logic OTP_RD_EN,
  output logic OTP_SEC_RD,
  output logic [sbl_pkg::OTP_AW-1:0] OTP_ADDR,
  input wire logic [31:0] OTP_RDATA,
  // otp programming side
  output sbl_pkg::sbl_pgm_s OTP_PGM_O,
  output logic OTP_REDUND,
  // ram load and start
  output sbl_pkg::sbl_ram_s RAM_O,
  output logic BOOT_START,
  output logic [15:0] BOOT_ADDR,
  output logic BOOT_FAIL,
  // security gates
  output logic JTAG_BLOCK,
  output logic LINK_BLOCK,
  input wire logic JTAG_OTP_REQ,
  output logic JTAG_OTP_OK,
  output logic [9:0] USERCODE_EXT
);
  // ****************************************
  // helpers
  // ****************************************
  // one byte of reflected crc32
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ sbl_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // merge write data by byte lanes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // ****************************************
  // state
  // ****************************************
  sbl_pkg::sbl_state_s q; // registered state
  sbl_pkg::sbl_state_s n; // next state
  logic byte_v; // a boot byte is ready
  logic [7:0] byte_b; // that byte
  logic [31:0] word; // word with the new byte on top
  logic ck_rise; // sampled flash clock edge
  logic wb_hit; // new bus request
  logic [31:0] wm; // merged write data
  logic [1:0] sect; // sector of program address
  // ****************************************
  // next state logic
  // ****************************************
  // one process for boot, parser and bus
  always_comb begin
    n = q;
    byte_v = 1'b0;
    byte_b = 8'h00;
    n.ram.we = 1'b0;
    n.start = 1'b0;
    n.pgm.row = 1'b0;
    n.pgm.sec = 1'b0;
    // two-stage samplers, edge seen past stage two
    n.ck1 = FL_SCK;
    n.ck2 = q.ck1;
    n.ck3 = q.ck2;
    n.dt1 = FL_MISO;
    n.dt2 = q.dt1;
    ck_rise = q.ck2 & ~q.ck3;
    unique case (q.st)
      // internal reset wait
      sbl_pkg::S_RST: begin
        if (q.dly == sbl_pkg::DLY_W'(DLY_CYC - 1)) begin
          n.st = sbl_pkg::S_SECRD;
        end else begin
          n.dly = q.dly + 1'b1;
        end
      end
      // security word read issued
      sbl_pkg::S_SECRD: n.st = sbl_pkg::S_SECCAP;
      // capture it and pick the source
      sbl_pkg::S_SECCAP: begin
        n.sec = OTP_RDATA;
        n.src_otp = OTP_RDATA[sbl_pkg::SEC_OTPBOOT];
        if (OTP_RDATA[sbl_pkg::SEC_OTPBOOT]) begin
          n.st = sbl_pkg::S_ORD;
        end else begin
          n.st = sbl_pkg::S_FL;
          n.fl_cs_n = 1'b0;
        end
      end
      // flash: msb first bits on sampled rise
      sbl_pkg::S_FL: begin
        if (ck_rise) begin
          n.shf = {q.shf[6:0], q.dt2};
          n.bitc = q.bitc + 1'b1;
          if (q.bitc == 3'h7) begin
            byte_v = 1'b1;
            byte_b = {q.shf[6:0], q.dt2};
          end
        end
      end
      // otp: read one row from address zero up
      sbl_pkg::S_ORD: n.st = sbl_pkg::S_OCAP;
      sbl_pkg::S_OCAP: begin
        n.otpw = OTP_RDATA;
        n.otp_a = q.otp_a + 1'b1;
        n.bsel = 2'h0;
        n.st = sbl_pkg::S_OBYTE;
      end
      // hand out the row low byte first
      sbl_pkg::S_OBYTE: begin
        byte_v = 1'b1;
        byte_b = q.otpw[7:0];
        n.otpw = q.otpw >> 8;
        n.bsel = q.bsel + 1'b1;
        if (q.bsel == 2'h3) begin
          n.st = sbl_pkg::S_ORD;
        end
      end
      // end states hold
      sbl_pkg::S_RUN, sbl_pkg::S_FAIL: n.st = q.st;
      default: n.st = sbl_pkg::S_FAIL; // stray code parks in failure
    endcase
    // ****************************************
    // image parser
    // ****************************************
    word = {byte_b, q.wrd[31:8]};
    if (byte_v) begin
      n.wrd = word;
      n.bidx = q.bidx + 1'b1;
      if (q.ph != sbl_pkg::PH_CRC) begin
        n.crc = crc_byte(q.crc, byte_b);
      end
      if (q.bidx == 2'h3) begin
        unique case (q.ph)
          // word count; zero goes straight to checksum
          sbl_pkg::PH_CNT: begin
            n.cnt = word;
            n.ph = (word == 32'h00000000) ? sbl_pkg::PH_CRC : sbl_pkg::PH_PRG;
          end
          // program words land from ram zero up
          sbl_pkg::PH_PRG: begin
            n.ram.we = 1'b1;
            n.ram.adr = q.raddr;
            n.ram.dat = word;
            n.raddr = q.raddr + 1'b1;
            n.cnt = q.cnt - 1'b1;
            if (q.cnt == 32'h00000001) begin
              n.ph = sbl_pkg::PH_CRC;
            end
          end
          // trailing word: bypass or inverted residue
          sbl_pkg::PH_CRC: begin
            n.fl_cs_n = 1'b1;
            if (word == sbl_pkg::CRC_BYPASS || word == ~q.crc) begin
              n.st = sbl_pkg::S_RUN;
              n.start = 1'b1;
              n.done = 1'b1;
            end else begin
              n.st = sbl_pkg::S_FAIL;
              n.fail = 1'b1;
            end
          end
          default: n.st = sbl_pkg::S_FAIL;
        endcase
      end
    end
    // ****************************************
    // wishbone slave
    // ****************************************
    wb_hit = WB_I.cyc & WB_I.stb & ~q.ack;
    n.ack = wb_hit; // ack one cycle after the request
    wm = 32'h00000000;
    sect = q.paddr[10:9];
    if (wb_hit && !WB_I.we) begin
      unique case (WB_I.adr)
        sbl_pkg::ADR_SEC: n.rdat = q.sec;
        sbl_pkg::ADR_STAT: n.rdat = {27'h0, q.rej, q.src_otp, q.fail, q.done,
                                     (q.st != sbl_pkg::S_RUN && q.st != sbl_pkg::S_FAIL)};
        sbl_pkg::ADR_PADDR: n.rdat = {16'h0000, q.paddr};
        sbl_pkg::ADR_PDATA: n.rdat = q.pdata;
        default: n.rdat = 32'h00000000; // unmapped reads zero
      endcase
    end
    if (wb_hit && WB_I.we) begin
      unique case (WB_I.adr)
        // only the general field is software writable
        sbl_pkg::ADR_SEC: begin
          wm = wmerge(n.sec, WB_I.dat, WB_I.sel); // on n.sec: a load this cycle survives
          n.sec = (n.sec & ~sbl_pkg::SEC_GP_MASK) | (wm & sbl_pkg::SEC_GP_MASK);
        end
        // write one to drop the reject flag
        sbl_pkg::ADR_STAT: begin
          wm = wmerge(32'h00000000, WB_I.dat, WB_I.sel);
          if (wm[sbl_pkg::STAT_REJ]) begin
            n.rej = 1'b0;
          end
        end
        // address and data ports of programming
        sbl_pkg::ADR_PADDR: begin
          wm = wmerge({16'h0000, q.paddr}, WB_I.dat, WB_I.sel);
          n.paddr = wm[15:0];
        end
        sbl_pkg::ADR_PDATA: n.pdata = wmerge(q.pdata, WB_I.dat, WB_I.sel);
        // control port: locks decide each request
        sbl_pkg::ADR_PCTRL: begin
          wm = wmerge(32'h00000000, WB_I.dat, WB_I.sel);
          n.pgm.adr = q.paddr;
          n.pgm.dat = q.pdata;
          if (wm[sbl_pkg::CTRL_ROW]) begin
            if (q.sec[sbl_pkg::SEC_MLOCK] || q.sec[sbl_pkg::SEC_LOCK0 + sect]
                || q.paddr >= 16'(sbl_pkg::OTP_SECTORS * sbl_pkg::OTP_ROWS)) begin
              n.rej = 1'b1;
            end else begin
              n.pgm.row = 1'b1;
            end
          end
          if (wm[sbl_pkg::CTRL_SEC]) begin
            if (q.sec[sbl_pkg::SEC_MLOCK]) begin
              n.rej = 1'b1;
            end else begin
              n.pgm.sec = 1'b1;
            end
          end
        end
        default: n.rej = q.rej; // unmapped writes are dropped
      endcase
    end
  end
  // ****************************************
  // state register
  // ****************************************
  // async reset to constants only
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.st <= sbl_pkg::S_RST;
      q.ph <= sbl_pkg::PH_CNT;
      q.sec <= sbl_pkg::SEC_RESET;
      q.crc <= sbl_pkg::CRC_INIT;
      q.fl_cs_n <= 1'b1;
    end else begin
      q <= n;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign GPIO_PD_EN = ~RST_N;
  assign WB_DAT_O = q.rdat;
  assign WB_ACK_O = q.ack;
  assign FL_CS_N = q.fl_cs_n;
  assign OTP_RD_EN = (q.st == sbl_pkg::S_SECRD) || (q.st == sbl_pkg::S_ORD);
  assign OTP_SEC_RD = (q.st == sbl_pkg::S_SECRD);
  assign OTP_ADDR = q.otp_a;
  assign OTP_PGM_O = q.pgm;
  assign OTP_REDUND = q.sec[sbl_pkg::SEC_REDUND];
  assign RAM_O = q.ram;
  assign BOOT_START = q.start;
  assign BOOT_ADDR = sbl_pkg::BOOT_ENTRY;
  assign BOOT_FAIL = q.fail;
  assign JTAG_BLOCK = q.sec[sbl_pkg::SEC_NOJTAG];
  assign LINK_BLOCK = q.sec[sbl_pkg::SEC_NOLINK];
  // gate is a handshake, so it may stay combinational
  assign JTAG_OTP_OK = JTAG_OTP_REQ & ~q.sec[sbl_pkg::SEC_NOJOTP];
  assign USERCODE_EXT = q.sec[31:sbl_pkg::SEC_UID_LO];
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  a_boot_delay: assert property (
    (q.st == sbl_pkg::S_RST && q.dly == 9'h000) |-> ##300 (q.st == sbl_pkg::S_SECRD))
    else $error("boot wait length wrong");
  a_src_pick: assert property (
    (q.st == sbl_pkg::S_SECCAP) |=>
    (q.st == ($past(OTP_RDATA[sbl_pkg::SEC_OTPBOOT]) ? sbl_pkg::S_ORD : sbl_pkg::S_FL)))
    else $error("boot source not from bit 5");
  a_sec_load: assert property (
    (q.st == sbl_pkg::S_SECCAP) |=> (q.sec == $past(OTP_RDATA)))
    else $error("security word not loaded");
  a_fail_nostart: assert property (
    $rose(q.fail) |-> !q.start ##1 !q.start[*8])
    else $error("start given after failure");
  a_ram_order: assert property (
    q.ram.we |-> (q.raddr == q.ram.adr + 16'h0001) && BOOT_ADDR == 16'h0000)
    else $error("ram load order wrong");
  a_jtag_gate: assert property (
    q.sec[0] |-> JTAG_BLOCK && q.sec[1] == LINK_BLOCK)
    else $error("jtag or link gate open");
  a_jtag_otp: assert property (
    JTAG_OTP_OK |-> !q.sec[13] && JTAG_OTP_REQ)
    else $error("jtag otp access while blocked");
  a_sector_lock: assert property (
    q.pgm.row |-> !q.sec[sbl_pkg::SEC_LOCK0 + q.pgm.adr[10:9]] && q.pgm.adr < 16'h0800)
    else $error("locked sector programmed");
  a_master_lock: assert property (
    (q.pgm.row || q.pgm.sec) |-> !$past(q.sec[12]))
    else $error("program under master lock");
  a_ack_pulse: assert property (
    q.ack |=> !q.ack)
    else $error("ack longer than one cycle");

endmodule
`default_nettype wire

// ===== bench/sbl_mem_model.sv
// Purpose: boot memory partner, otp rows plus serial boot flash
// Assumes: bench loads img bytes in stream order and sec_word
// Notes: flash clock stands still while deselected
`timescale 1ns/100ps
`default_nettype none
module sbl_mem_model (
  // clock
  input wire logic clk,
  // otp read side
  input wire logic rd_en,
  input wire logic sec_rd,
  input wire logic [10:0] addr,
  output logic [31:0] rdata,
  // flash side
  input wire logic cs_n,
  output logic sck,
  output logic miso
);
  logic [31:0] sec_word; // security word held in otp
  logic [7:0] img [0:63]; // boot image bytes
  int k; // bit index in stream
  // otp answers one cycle after the strobe, garbage otherwise
  always @(posedge clk) begin
    if (rd_en) begin
      rdata <= sec_rd ? sec_word : {img[{addr[3:0], 2'h3}], img[{addr[3:0], 2'h2}],
        img[{addr[3:0], 2'h1}], img[{addr[3:0], 2'h0}]};
    end else begin
      rdata <= ~rdata;
    end
  end
  // flash: msb first, data moves on the falling clock edge
  initial begin
    sck = 1'b0;
    miso = 1'b0;
    rdata = 32'h0;
    forever begin
      @(negedge cs_n);
      #73;
      k = 0;
      while (!cs_n) begin
        miso = (k < 512) ? img[k/8][7-k%8] : ~miso;
        #200 sck = 1'b1;
        #200 sck = 1'b0;
        k++;
      end
      miso = ~miso; // released line carries no stale value
    end
  end
endmodule
`default_nettype wire

// ===== bench/secure_boot_loader_bench.sv
// Purpose: boot, security gating and otp programming checks
// Assumes: design wait count left at its default
// Notes: each boot is started by a fresh reset
`timescale 1ns/100ps
`default_nettype none
module secure_boot_loader_bench;
  logic clk;
  logic rst_n;
  sbl_pkg::sbl_wb_s wb; // bus request
  logic [31:0] rd;
  logic ack, pd, cs_n, sck, miso, rden, secrd, redund, start, fail, jblk, lblk, jreq, jok;
  logic [10:0] oaddr;
  logic [31:0] odata;
  sbl_pkg::sbl_pgm_s pgm;
  sbl_pkg::sbl_ram_s ramo;
  logic [15:0] baddr;
  logic [9:0] uce;
  logic [31:0] ram [0:15]; // captured ram words
  logic [47:0] pgm_last; // last program address and data
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc_n = 0;
  int n_wr, n_start, n_pgm, n_cs;
  sbl_top DUT (.REF_CLK(clk), .RST_N(rst_n), .WB_I(wb), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .GPIO_PD_EN(pd), .FL_CS_N(cs_n), .FL_SCK(sck), .FL_MISO(miso), .OTP_RD_EN(rden),
    .OTP_SEC_RD(secrd), .OTP_ADDR(oaddr), .OTP_RDATA(odata), .OTP_PGM_O(pgm),
    .OTP_REDUND(redund), .RAM_O(ramo), .BOOT_START(start), .BOOT_ADDR(baddr),
    .BOOT_FAIL(fail), .JTAG_BLOCK(jblk), .LINK_BLOCK(lblk), .JTAG_OTP_REQ(jreq),
    .JTAG_OTP_OK(jok), .USERCODE_EXT(uce));
  sbl_mem_model u_mem (.clk(clk), .rd_en(rden), .sec_rd(secrd), .addr(oaddr),
    .rdata(odata), .cs_n(cs_n), .sck(sck), .miso(miso));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // monitors of ram, start, program pulses, flash select; hang guard
  always @(posedge clk) begin
    if (ramo.we === 1'b1) begin
      ram[ramo.adr[3:0]] <= ramo.dat;
      n_wr <= n_wr + 1;
    end
    if (start === 1'b1) n_start <= n_start + 1;
    if (pgm.row === 1'b1 || pgm.sec === 1'b1) begin
      n_pgm <= n_pgm + 1;
      pgm_last <= {pgm.adr, pgm.dat};
    end
    if (cs_n === 1'b0) n_cs <= n_cs + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack, release, idle one cycle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    wb <= {1'b1, 1'b1, w, 4'hF, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    wb <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int j = 0; j < 8; j++) begin
      r = r[0] ? (r >> 1) ^ sbl_pkg::CRC_POLY : r >> 1;
    end
    return r;
  endfunction
  // mode 0 good crc, 1 bypass word, 2 corrupted crc
  task automatic boot(input logic [31:0] sec, input int mode);
    logic [31:0] w [0:3];
    logic [31:0] c;
    int t;
    w = '{32'h2, 32'h11223344, 32'hA5C30F96, 32'h0};
    c = sbl_pkg::CRC_INIT;
    for (int i = 0; i < 12; i++) begin
      c = crc_step(c, w[i/4][8*(i%4)+:8]);
    end
    w[3] = (mode == 1) ? sbl_pkg::CRC_BYPASS : ~c ^ {31'h0, mode == 2};
    for (int i = 0; i < 16; i++) begin
      u_mem.img[i] = w[i/4][8*(i%4)+:8];
    end
    u_mem.sec_word = sec;
    ram[0] = 32'h0; // stale words from the last boot must not pass
    ram[1] = 32'h0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(pd, 1);
    chk({cs_n, jblk}, 2'h3);
    rst_n <= 1'b1;
    n_wr = 0;
    n_start = 0;
    n_cs = 0;
    t = 0;
    while (rden !== 1'b1) begin
      @(posedge clk);
      t++;
    end
    chk(t >= sbl_pkg::BOOT_DLY_CYC && t <= 3000, 1);
    chk(pd, 0);
    while (n_start == 0 && fail !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    chk({n_start, n_wr}, (mode == 2) ? 48'h0000_0000_0002 : 48'h0001_0000_0002);
    chk(fail, mode == 2);
    chk({ram[0], ram[1]}, {w[1], w[2]});
    chk(baddr, 0);
    chk(n_cs == 0, sec[5]);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    wb = '0;
    jreq = 1'b0;
    pgm_last = '0;
    n_pgm = 0;
    boot(32'h8A40_2181, 0);
    rd_chk(sbl_pkg::ADR_SEC, 32'hFFFFFFFF, 32'h8A40_2181);
    jreq <= 1'b1;
    @(posedge clk);
    chk({jblk, lblk, redund, jok}, 4'hA);
    chk(uce, 10'h229);
    wr(sbl_pkg::ADR_SEC, 32'hFFFFFFFF);
    rd_chk(sbl_pkg::ADR_SEC, 32'hFFFFFFFF, 32'h8A40_2181 | sbl_pkg::SEC_GP_MASK);
    wr(sbl_pkg::ADR_PADDR, 32'h0010);
    wr(sbl_pkg::ADR_PDATA, 32'h5A5A1234);
    wr(sbl_pkg::ADR_PCTRL, 32'h1);
    rd_chk(sbl_pkg::ADR_STAT, 32'h10, 32'h10);
    chk(n_pgm, 0);
    wr(sbl_pkg::ADR_STAT, 32'h10);
    rd_chk(sbl_pkg::ADR_STAT, 32'h10, 32'h0);
    wr(sbl_pkg::ADR_PADDR, 32'h0210);
    wr(sbl_pkg::ADR_PCTRL, 32'h1);
    wr(sbl_pkg::ADR_PCTRL, 32'h2);
    chk({n_pgm[15:0], pgm_last}, {16'h2, 16'h0210, 32'h5A5A1234});
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    boot(32'h0000_0002, 1);
    chk({jblk, lblk, jok}, 3'h3);
    boot(32'h0, 2);
    boot(32'h0000_1020, 0);
    n_pgm = 0;
    wr(sbl_pkg::ADR_PADDR, 32'h0600);
    wr(sbl_pkg::ADR_PCTRL, 32'h1);
    wr(sbl_pkg::ADR_PCTRL, 32'h2);
    chk(n_pgm, 0);
    rd_chk(sbl_pkg::ADR_STAT, 32'h10, 32'h10);
    end_sim();
  end
endmodule
`default_nettype wire
